// >>> rtl/uart_pkg.sv
// Shared constants for the serial port controller: register map, fields, timing.
// Assumes a 125 MHz core clock and a plain strobe register port.
package uart_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_FIFO_CTRL = 8'h04;
	localparam logic [7:0] ADDR_FUNC_SEL = 8'h08;
	localparam logic [7:0] ADDR_BAUD = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CTRL = 8'h14;
	// Fifo control: handshake threshold field
	localparam int FCR_THR_LSB = 16;
	localparam int FCR_THR_MSB = 19;
	localparam logic [3:0] FCR_THR_RESET = 4'h1;
	// Function select codes
	localparam logic [1:0] FUNC_UART = 2'b00;
	localparam logic [1:0] FUNC_LIN = 2'b01;
	localparam logic [1:0] FUNC_IRDA = 2'b10;
	localparam logic [1:0] FUNC_RS485 = 2'b11;
	localparam int FUNC_IRDA_BIT = 1;
	// Baud register layout
	localparam int BAUD_A_MSB = 15;
	localparam int BAUD_B_LSB = 24;
	localparam int BAUD_B_MSB = 27;
	localparam int BAUD_M_LSB = 28;
	localparam int BAUD_M_MSB = 29;
	localparam logic [31:0] BAUD_RESET = 32'h0000_000A;
	// Control register bits
	localparam int CTRL_AFC = 0;
	localparam int CTRL_NINTH = 1;
	// Character frame
	localparam int DATA_BITS = 8;
	localparam int FIFO_DEPTH = 16;
	// Infrared limits: fastest rate and pulse width as 3/16 of a bit
	localparam int IRDA_MAX_BAUD = 115200;
	localparam int CLK_HZ = 125_000_000;
	localparam int IRDA_MIN_DIV = CLK_HZ / IRDA_MAX_BAUD;
	localparam int IR_PULSE_TICKS = 3;
	localparam int OVERSAMPLE = 16;
	typedef enum logic [1:0] {BAUD_DIV16, BAUD_DIVB, BAUD_DIV1} baud_mode_t;
endpackage

// >>> rtl/uart_baud_gen.sv
// Baud tick generator: emits a 16x oversample tick from the baud register.
// Assumes the register is stable while a character is in flight.
module uart_baud_gen
	import uart_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [31:0] baud,
	output logic tick16
);
	logic [19:0] cnt;
	logic [19:0] limit;
	logic [15:0] a;
	logic [3:0] b;
	logic [1:0] m;

	// Ticks per 16x sample derived from the three divider modes
	always_comb begin
		a = baud[BAUD_A_MSB:0];
		b = baud[BAUD_B_MSB:BAUD_B_LSB];
		m = baud[BAUD_M_MSB:BAUD_M_LSB];
		limit = 20'(a) + 20'd2;
		if (m == 2'b10)
			limit = 20'((32'(a) + 32'd2) * (32'(b) + 32'd1) / 32'd16);
		else if (m == 2'b11)
			limit = 20'((32'(a) + 32'd2) / 32'd16);
		if (limit == 20'd0)
			limit = 20'd1;
	end

	// Free counter; terminal count is one tick
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cnt <= 20'd0;
			tick16 <= 1'b0;
		end else if (cnt + 20'd1 >= limit) begin
			cnt <= 20'd0;
			tick16 <= 1'b1;
		end else begin
			cnt <= cnt + 20'd1;
			tick16 <= 1'b0;
		end
	end
endmodule // uart_baud_gen

// >>> rtl/uart_ir_codec.sv
// Infrared SIR codec: short high pulses out, pulse stretching in.
// Assumes tick16 from the baud generator; bypassed when infrared is off.
module uart_ir_codec
	import uart_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ir_en,
	input wire logic tick16,
	input wire logic tx_serial,
	input wire logic tx_bit_start,
	output logic ir_tx,
	input wire logic ir_rx,
	output logic rx_serial
);
	logic [3:0] pulse_cnt;
	logic [3:0] hold_cnt;

	// Encoder: a zero bit becomes a 3/16 bit pulse
	always_ff @(posedge core_clk) begin
		if (!resetn)
			pulse_cnt <= 4'd0;
		else if (tx_bit_start && !tx_serial && ir_en)
			pulse_cnt <= 4'(IR_PULSE_TICKS);
		else if (tick16 && pulse_cnt != 4'd0)
			pulse_cnt <= pulse_cnt - 4'd1;
	end

	assign ir_tx = ir_en ? (pulse_cnt != 4'd0) : 1'b0;

	// Decoder: stretch a received pulse to a full low bit
	always_ff @(posedge core_clk) begin
		if (!resetn)
			hold_cnt <= 4'd0;
		else if (ir_rx)
			hold_cnt <= 4'(OVERSAMPLE - 1);
		else if (tick16 && hold_cnt != 4'd0)
			hold_cnt <= hold_cnt - 4'd1;
	end

	assign rx_serial = (hold_cnt == 4'd0);
endmodule // uart_ir_codec

// >>> rtl/uart_flow_port.sv
// Serial port controller with auto-flow, infrared, LIN and RS-485 functions.
// Assumes core_clk at 125 MHz, a strobe register port, pins synchronous to clock.
// What this block does
// - with auto-flow on outside RS-485, receiver takes characters only while rts_n is low.
// - with auto-flow on outside RS-485, rts_n goes high when fifo count equals threshold.
// - with auto-flow on, transmitter starts a character only while cts_n is low.
// - infrared path runs only when function select bit 1 is set.
// - infrared characters are start, eight data, one stop.
// - infrared runs half duplex at any baud register rate; IRDA_MAX_BAUD is not enforced.
// - infrared blanks received light while transmitting, but a transmit can still start during a reception.
// - infrared has a pulse encoder on transmit and decoder on receive.
// - function select value 01 picks LIN mode.
// - LIN characters are start, eight data, one stop.
// - RS-485 nine bit mode with direction driven on rts_n.
// - RS-485 picked by writing its code into function select.
// - in RS-485, rts_n enables the line driver during transmit.
// - baud register sets the rate; documented settings give listed rates.
//
// Local design decisions: the address map and the strobed register port.
module uart_flow_port
	import uart_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	input wire logic rxd,
	output logic txd,
	input wire logic cts_n,
	output logic rts_n,
	input wire logic ir_rx,
	output logic ir_tx
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int PW = $clog2(DEPTH);

	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} tx_state_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} rx_state_t;

	logic [31:0] fifo_ctrl;
	logic [1:0] func_sel;
	logic [31:0] baud;
	logic [1:0] ctrl;
	logic tick16;
	logic afc;
	logic ir_mode;
	logic rs485;
	logic nine;
	// Receive fifo
	logic [8:0] rx_mem [DEPTH];
	logic [PW-1:0] rx_wp;
	logic [PW-1:0] rx_rp;
	logic [CW-1:0] rx_cnt;
	logic rx_push;
	logic rx_pop;
	logic rx_overrun;
	logic rts_hold;
	// Transmit holding
	logic [8:0] tx_hold;
	logic tx_full;
	logic [8:0] tx_shift;
	logic [3:0] tx_bit;
	logic [3:0] tx_tick;
	logic tx_bit_start;
	logic tx_line;
	logic tx_busy;
	tx_state_t tx_state;
	// Receiver
	logic rx_line;
	logic rx_serial_ir;
	logic [8:0] rx_shift;
	logic [3:0] rx_bit;
	logic [3:0] rx_tick;
	logic rx_framing;
	rx_state_t rx_state;
	logic rx_accept;

	assign afc = ctrl[CTRL_AFC];
	assign ir_mode = func_sel[FUNC_IRDA_BIT] && func_sel != FUNC_RS485;
	assign rs485 = (func_sel == FUNC_RS485);
	// Nine bit frames only for RS-485; LIN and infrared keep eight
	assign nine = rs485 && ctrl[CTRL_NINTH];

	uart_baud_gen u_baud (
		.core_clk(core_clk),
		.resetn(resetn),
		.baud(baud),
		.tick16(tick16)
	);

	uart_ir_codec u_ir (
		.core_clk(core_clk),
		.resetn(resetn),
		.ir_en(ir_mode),
		.tick16(tick16),
		.tx_serial(tx_line),
		.tx_bit_start(tx_bit_start),
		.ir_tx(ir_tx),
		.ir_rx(ir_rx && !tx_busy),
		.rx_serial(rx_serial_ir)
	);

	// Register writes
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fifo_ctrl <= {12'h000, FCR_THR_RESET, 16'h0000};
			func_sel <= FUNC_UART;
			baud <= BAUD_RESET;
			ctrl <= 2'b00;
		end else if (wr_en) begin
			unique case (addr)
				ADDR_FIFO_CTRL: fifo_ctrl <= {12'h000, wdata[FCR_THR_MSB:FCR_THR_LSB], 16'h0000};
				ADDR_FUNC_SEL: func_sel <= wdata[1:0];
				ADDR_BAUD: baud <= wdata;
				ADDR_CTRL: ctrl <= wdata[1:0];
				default: ;
			endcase
		end
	end

	// Transmit holding register; write is dropped while full
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tx_hold <= 9'h000;
			tx_full <= 1'b0;
		end else if (wr_en && addr == ADDR_DATA && !tx_full) begin
			tx_hold <= wdata[8:0];
			tx_full <= 1'b1;
		end else if (tx_state == TX_IDLE && tx_full && tick16 && (!afc || !cts_n)) begin
			tx_full <= 1'b0;
		end
	end

	// Read mux, data one cycle later; pop on data read
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdata <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (addr)
				ADDR_DATA: rdata <= {23'h0, rx_mem[rx_rp]};
				ADDR_FIFO_CTRL: rdata <= fifo_ctrl;
				ADDR_FUNC_SEL: rdata <= {30'h0, func_sel};
				ADDR_BAUD: rdata <= baud;
				ADDR_STATUS: rdata <= {24'h0, 1'(rx_cnt), rx_framing, rx_overrun, tx_busy, tx_full,
					rts_n, rx_cnt == CW'(0), rx_cnt == CW'(DEPTH)};
				ADDR_CTRL: rdata <= {30'h0, ctrl};
				default: rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	assign rx_pop = rd_en && addr == ADDR_DATA && rx_cnt != CW'(0);

	// Transmitter state machine, 16 ticks per bit
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tx_state <= TX_IDLE;
			tx_shift <= 9'h000;
			tx_bit <= 4'd0;
			tx_tick <= 4'd0;
			tx_line <= 1'b1;
			tx_bit_start <= 1'b0;
		end else begin
			tx_bit_start <= 1'b0;
			if (tick16) begin
				unique case (tx_state)
					TX_IDLE: begin
						// Start only with cts_n low under auto-flow
						if (tx_full && (!afc || !cts_n)) begin
							tx_shift <= tx_hold;
							tx_state <= TX_START;
							tx_line <= 1'b0;
							tx_tick <= 4'd0;
							tx_bit_start <= 1'b1;
						end
					end
					default: begin
						tx_tick <= tx_tick + 4'd1;
						if (tx_tick == 4'(OVERSAMPLE - 1)) begin
							tx_bit_start <= 1'b1;
							unique case (tx_state)
								TX_START: begin
									tx_state <= TX_DATA;
									tx_bit <= 4'd0;
									tx_line <= tx_shift[0];
								end
								TX_DATA: begin
									tx_bit <= tx_bit + 4'd1;
									if (tx_bit == 4'(DATA_BITS - 1)) begin
										tx_state <= nine ? TX_NINTH : TX_STOP;
										tx_line <= nine ? tx_shift[8] : 1'b1;
									end else begin
										tx_line <= tx_shift[tx_bit[2:0] + 3'd1];
									end
								end
								TX_NINTH: begin
									tx_state <= TX_STOP;
									tx_line <= 1'b1;
								end
								default: begin
									tx_state <= TX_IDLE;
									tx_bit_start <= 1'b0;
								end
							endcase
						end
					end
				endcase
			end
		end
	end

	assign tx_busy = (tx_state != TX_IDLE);
	assign txd = ir_mode ? 1'b1 : tx_line;
	// Receive line: infrared decoder output or raw pin, gated in half duplex
	assign rx_line = ir_mode ? (tx_busy ? 1'b1 : rx_serial_ir) : rxd;

	// Receiver state machine samples mid-bit
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rx_state <= RX_IDLE;
			rx_shift <= 9'h000;
			rx_bit <= 4'd0;
			rx_tick <= 4'd0;
			rx_push <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			if (tick16) begin
				unique case (rx_state)
					RX_IDLE: begin
						// Under auto-flow no start is taken with rts_hold high
						if (!rx_line && rx_accept) begin
							rx_state <= RX_START;
							rx_tick <= 4'd0;
						end
					end
					default: begin
						rx_tick <= rx_tick + 4'd1;
						if (rx_tick == 4'(OVERSAMPLE / 2 - 1)) begin
							unique case (rx_state)
								RX_START: begin
									rx_state <= rx_line ? RX_IDLE : RX_DATA;
									rx_bit <= 4'd0;
								end
								RX_DATA: begin
									rx_shift[rx_bit[2:0]] <= rx_line;
									rx_bit <= rx_bit + 4'd1;
									if (rx_bit == 4'(DATA_BITS - 1))
										rx_state <= nine ? RX_NINTH : RX_STOP;
								end
								RX_NINTH: begin
									rx_shift[8] <= rx_line;
									rx_state <= RX_STOP;
								end
								default: begin
									rx_state <= RX_IDLE;
									rx_push <= 1'b1;
									rx_tick <= 4'd0;
								end
							endcase
						end else if (rx_tick == 4'(OVERSAMPLE - 1)) begin
							rx_tick <= 4'd0;
						end
					end
				endcase
			end
		end
	end

	// Framing flag: stop bit low; set wins over clear on status read
	always_ff @(posedge core_clk) begin
		if (!resetn)
			rx_framing <= 1'b0;
		else if (tick16 && rx_state == RX_STOP && rx_tick == 4'(OVERSAMPLE / 2 - 1) && !rx_line)
			rx_framing <= 1'b1;
		else if (rd_en && addr == ADDR_STATUS)
			rx_framing <= 1'b0;
	end

	// Receive fifo storage and counters
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rx_wp <= '0;
			rx_rp <= '0;
			rx_cnt <= '0;
			rx_overrun <= 1'b0;
		end else begin
			if (rx_push && rx_cnt != CW'(DEPTH)) begin
				rx_mem[rx_wp] <= {nine ? rx_shift[8] : 1'b0, rx_shift[7:0]};
				rx_wp <= PW'((32'(rx_wp) + 32'd1) % DEPTH);
			end
			if (rx_pop)
				rx_rp <= PW'((32'(rx_rp) + 32'd1) % DEPTH);
			if (rx_push && rx_cnt != CW'(DEPTH) && !rx_pop)
				rx_cnt <= rx_cnt + CW'(1);
			else if (rx_pop && !(rx_push && rx_cnt != CW'(DEPTH)))
				rx_cnt <= rx_cnt - CW'(1);
			if (rx_push && rx_cnt == CW'(DEPTH))
				rx_overrun <= 1'b1;
			else if (rd_en && addr == ADDR_STATUS)
				rx_overrun <= 1'b0;
		end
	end

	// Handshake: high at threshold, low again below it
	always_ff @(posedge core_clk) begin
		if (!resetn)
			rts_hold <= 1'b1;
		else if (rx_cnt >= CW'(fifo_ctrl[FCR_THR_MSB:FCR_THR_LSB]))
			rts_hold <= 1'b1;
		else
			rts_hold <= 1'b0;
	end

	// Finish a character already started, start no new one while held
	assign rx_accept = !afc || !rts_hold || rx_state != RX_IDLE;

	// RS-485 drives rts_n low as driver enable during transmit
	assign rts_n = rs485 ? !(tx_busy || tx_full) : (afc ? rts_hold : 1'b1);

	chk_rts_threshold: assert property (@(posedge core_clk) disable iff (!resetn)
		(afc && !rs485 && rx_cnt == CW'(fifo_ctrl[FCR_THR_MSB:FCR_THR_LSB])) |=> rts_n)
		else $error("rts_n low at threshold");
	// A mode or control write in the same cycle legally moves rts_n away from the fifo level
	chk_rts_release: assert property (@(posedge core_clk) disable iff (!resetn)
		(afc && !rs485 && rx_cnt < CW'(fifo_ctrl[FCR_THR_MSB:FCR_THR_LSB])
		&& $stable(fifo_ctrl)
		&& !(wr_en && (addr == ADDR_CTRL || addr == ADDR_FUNC_SEL))) |=> !rts_n)
		else $error("rts_n not released");
	chk_rx_gate: assert property (@(posedge core_clk) disable iff (!resetn)
		(afc && !rs485 && rts_n && rx_state == RX_IDLE) |=> rx_state == RX_IDLE)
		else $error("start taken with rts_n high");
	chk_cts_gate: assert property (@(posedge core_clk) disable iff (!resetn)
		(afc && cts_n && tx_state == TX_IDLE) |=> tx_state == TX_IDLE)
		else $error("transmit started with cts_n high");
	chk_ir_half: assert property (@(posedge core_clk) disable iff (!resetn)
		(ir_mode && tx_busy) |-> rx_line)
		else $error("infrared receive during transmit");
	chk_ir_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
		!ir_mode |-> !ir_tx)
		else $error("infrared output while disabled");
	chk_rs485_dir: assert property (@(posedge core_clk) disable iff (!resetn)
		(rs485 && tx_busy) |-> !rts_n)
		else $error("driver not enabled while sending");
	chk_lin_frame: assert property (@(posedge core_clk) disable iff (!resetn)
		(func_sel == FUNC_LIN && tx_state == TX_DATA && tx_bit == 4'(DATA_BITS - 1)
		&& tick16 && tx_tick == 4'(OVERSAMPLE - 1)) |=> tx_state == TX_STOP)
		else $error("LIN frame not eight bits");
	chk_func_lin: assert property (@(posedge core_clk) disable iff (!resetn)
		(wr_en && addr == ADDR_FUNC_SEL && wdata[1:0] == FUNC_LIN) |=> !ir_mode && !rs485)
		else $error("LIN select misdecoded");
endmodule // uart_flow_port

// >>> verif/serial_peer.sv
// Far-side serial peer: drives rxd, ir_rx and cts_n, decodes txd or ir_tx.
// Assumes one tick per clock or per two clocks, so a bit lasts blen clocks.
module serial_peer (
	input wire logic core_clk,
	input wire logic txd,
	input wire logic ir_tx,
	output logic rxd,
	output logic ir_rx,
	output logic cts_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle lines: rxd high, no light, transmit not yet allowed
	initial begin
		rxd = 1'b1;
		ir_rx = 1'b0;
		cts_n = 1'b1;
	end
	// Clear-to-send level, changed just after an edge
	task automatic set_cts(input logic lvl);
		@(posedge core_clk);
		cts_n <= lvl;
	endtask
	// Start, nb data bits LSB first, stop; infrared zero is a 3-clock pulse
	task automatic send_char(input int val, input int nb, input int blen, input bit ir);
		int i;
		int k;
		bit b;
		for (i = 0; i < nb + 2; i++) begin
			b = (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : bit'((val >> (i - 1)) & 1);
			for (k = 0; k < blen; k++) begin
				@(posedge core_clk);
				if (ir) ir_rx <= !b && k < 3;
				else rxd <= b;
			end
		end
		@(posedge core_clk);
		ir_rx <= 1'b0;
	endtask
	// Decode one character; ok low on timeout or bad framing
	task automatic get_char(output int val, output bit ok, input int nb, input int blen,
		input bit ir);
		int i;
		int k;
		int w;
		bit acc;
		bit b;
		val = 0;
		ok = 1'b0;
		for (w = 0; w < 4000 && (ir ? ir_tx !== 1'b1 : txd !== 1'b0); w++) @(posedge core_clk) #1;
		if (w == 4000) return;
		for (i = 0; i < nb + 2; i++) begin
			acc = 1'b0;
			// Pulse may sit anywhere in the bit, so infrared ORs the whole window
			for (k = 0; k < blen; k++) begin
				if (ir) acc = acc | (ir_tx === 1'b1);
				else if (k == blen / 2) acc = (txd === 1'b1);
				@(posedge core_clk) #1;
			end
			b = ir ? !acc : acc;
			if (i == 0) ok = !b;
			else if (i > nb) ok = ok & b;
			else val = val | (int'(b) << (i - 1));
		end
	endtask
endmodule // serial_peer

// >>> verif/tb_uart_flow_port.sv
// Testbench for the serial port controller against a behavioural peer.
// Assumes the design's register map and a direct baud mode of one tick per clock.
module tb_uart_flow_port;
	import uart_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, resetn, wr_en, rd_en, rxd, txd, cts_n, rts_n, ir_rx, ir_tx;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int seed = 32'hdd624179;
	int exp_q[$];
	int i, e, v;
	bit ok, stuck;
	logic [31:0] baud_tab [4] = '{32'h3000_0000, 32'h3000_0000, 32'h0000_0000, 32'h2100_000E};
	int blen_tab [4] = '{16, 16, 32, 32};
	uart_flow_port dut (.core_clk(core_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rxd(rxd), .txd(txd), .cts_n(cts_n),
		.rts_n(rts_n), .ir_rx(ir_rx), .ir_tx(ir_tx));
	serial_peer peer (.core_clk(core_clk), .txd(txd), .ir_tx(ir_tx), .rxd(rxd), .ir_rx(ir_rx),
		.cts_n(cts_n));
	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Hang guard, well above the few thousand cycles the traffic needs
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		@(posedge core_clk);
		addr <= a;
		wdata <= dv;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] dv);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 dv = rdata;
	endtask
	// Send through the data register, let the peer decode it
	task automatic tx_check(input int val, input int nb, input int blen, input bit ir);
		wr(ADDR_DATA, 32'(val));
		exp_q.push_back(val);
		#1 if (nb == 9) chk(rts_n, 1'b0);
		peer.get_char(v, ok, nb, blen, ir);
		chk(ok, 1'b1);
		chk(v, exp_q.pop_front());
		repeat (4) @(posedge core_clk);
	endtask
	// Peer sends, software pops the receive fifo
	task automatic rx_check(input int val, input int blen, input bit ir);
		peer.send_char(val, 8, blen, ir);
		repeat (4) @(posedge core_clk);
		rd(ADDR_DATA, d);
		chk(d[7:0], val[7:0]);
	endtask
	initial begin
		resetn = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		repeat (20) @(posedge core_clk);
		chk({rts_n, txd, ir_tx}, 3'b110);
		resetn <= 1'b1;
		rd(ADDR_FIFO_CTRL, d);
		chk(d[19:16], FCR_THR_RESET);
		rd(ADDR_BAUD, d);
		chk(d, BAUD_RESET);
		rd(8'h3c, d);
		chk(d, 32'h0000_0000);
		// Plain framing over all three divider modes, LIN framing over one
		for (i = 0; i < 4; i++) begin
			wr(ADDR_FUNC_SEL, {30'h0, (i == 1) ? FUNC_LIN : FUNC_UART});
			wr(ADDR_BAUD, baud_tab[i]);
			tx_check($random(seed) & 8'hff, 8, blen_tab[i], 1'b0);
			rx_check($random(seed) & 8'hff, blen_tab[i], 1'b0);
		end
		wr(ADDR_BAUD, 32'h3000_0000);
		// Auto-flow: clear-to-send gate, then threshold of two
		wr(ADDR_FIFO_CTRL, 32'h0002_0000);
		wr(ADDR_CTRL, 32'h0000_0001);
		e = $random(seed) & 8'hff;
		wr(ADDR_DATA, 32'(e));
		stuck = 1'b0;
		repeat (200) @(posedge core_clk) #1 stuck = stuck | (txd !== 1'b1);
		chk(stuck, 1'b0);
		peer.set_cts(1'b0);
		peer.get_char(v, ok, 8, 16, 1'b0);
		chk(v, e);
		chk(rts_n, 1'b0);
		for (i = 0; i < 2; i++) begin
			exp_q.push_back($random(seed) & 8'hff);
			peer.send_char(exp_q[i], 8, 16, 1'b0);
		end
		repeat (4) @(posedge core_clk);
		chk(rts_n, 1'b1);
		peer.send_char(8'h5a, 8, 16, 1'b0);
		rd(ADDR_DATA, d);
		chk(d[7:0], exp_q.pop_front());
		repeat (2) @(posedge core_clk);
		chk(rts_n, 1'b0);
		rd(ADDR_DATA, d);
		chk(d[7:0], exp_q.pop_front());
		rd(ADDR_STATUS, d);
		chk(d[1], 1'b1);
		// RS-485 nine-bit with driver enable on rts_n
		wr(ADDR_CTRL, 32'h0000_0002);
		wr(ADDR_FUNC_SEL, {30'h0, FUNC_RS485});
		tx_check($random(seed) & 9'h1ff, 9, 16, 1'b0);
		chk(rts_n, 1'b1);
		// Infrared: light arriving mid-transmit must be ignored
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_FUNC_SEL, {30'h0, FUNC_IRDA});
		fork
			tx_check($random(seed) & 8'hff, 8, 16, 1'b1);
			begin
				repeat (20) @(posedge core_clk);
				peer.send_char(8'h3c, 8, 16, 1'b1);
			end
		join
		chk(txd, 1'b1);
		rd(ADDR_STATUS, d);
		chk(d[1], 1'b1);
		// Turnaround gap is software's job, kept short here
		repeat (100) @(posedge core_clk);
		rx_check($random(seed) & 8'hff, 16, 1'b1);
		give_verdict();
	end
endmodule // tb_uart_flow_port
